// ===== hw/vlbw_pkg.sv
/*
 * Shared constants and types for the video capture line burst writer.
 * Assumes one system clock and an active-high asynchronous reset.
 */
// Overview of operation
// - split every captured line into 128-byte memory transfers.
// - at line end issue the remainder transfer, then advance address by stride.
// - final transfer size is this line's remainder, never a stale one.
// - two ping-ponged remainder registers per channel, alternating each line.
// - remainder registers read zero after reset or client abort until recomputed.
// - luma and chroma are separate clients with own transfers and remainders.
// - 422 to 420 downsampling makes each pair of chroma lines one; only every other chroma line is written.
// - upstream scaler always emits its programmed frame size.
package vlbw_pkg;
	localparam int unsigned BURST_BYTES = 128;
	localparam int unsigned BEAT_BYTES = 16;
	localparam int unsigned BEATS_PER_BURST = BURST_BYTES / BEAT_BYTES;
	localparam int unsigned NUM_CLIENTS = 2;
	localparam logic [0:0] CLIENT_LUMA = 1'h0;
	localparam logic [0:0] CLIENT_CHROMA = 1'h1;
	localparam logic [7:0] REM_RESET = 8'h00;
	localparam logic [31:0] ADDR_RESET = 32'h00000000;
	localparam int unsigned BUF_DEPTH = 2;

	typedef enum logic [3:0] {
		VLBW_IDLE = 4'b0001,
		VLBW_DATA = 4'b0010,
		VLBW_CMD = 4'b0100,
		VLBW_ADV = 4'b1000
	} vlbw_state_t;
endpackage : vlbw_pkg

// ===== hw/vlbw_skid.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes the writer side honours in_ready and the drain side may stall freely.
 */
module vlbw_skid import vlbw_pkg::*; #(
	parameter int unsigned WIDTH = 128
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_r [BUF_DEPTH];
	logic [WIDTH-1:0] mem_nxt [BUF_DEPTH];
	logic rd_r, rd_nxt, wr_r, wr_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_nxt = mem_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data;
			wr_nxt = ~wr_r;
		end
		if (pop) begin
			rd_nxt = ~rd_r;
		end
		case ({push, pop})
			2'b10: cnt_nxt = cnt_r + 2'h1;
			2'b01: cnt_nxt = cnt_r - 2'h1;
			default: cnt_nxt = cnt_r;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'h0;
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else begin
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
			mem_r <= mem_nxt;
		end
	end
endmodule : vlbw_skid

// ===== hw/vlbw_writer.sv
/*
 * Line burst writer: takes 16-byte beats of captured lines for a luma and a
 * chroma client, writes them to memory in 128-byte bursts plus a final
 * remainder transfer, then steps each client's line address by the shared line_stride.
 * Assumes the capture side marks the last beat of each line with a byte count
 * and that the memory side accepts beats in order, without waiting for their command.
 */
module vlbw_writer import vlbw_pkg::*; #(
	parameter int unsigned ADDR_W = 32,
	parameter int unsigned DATA_W = 128,
	parameter int unsigned LEN_W = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// configuration, held stable while capturing
	input wire logic [ADDR_W-1:0] luma_base,
	input wire logic [ADDR_W-1:0] chroma_base,
	input wire logic [ADDR_W-1:0] line_stride,
	input wire logic chroma_420,
	// capture client control
	input wire logic frame_start,
	input wire logic client_abort,
	// captured beats from the parser
	input wire logic cap_valid,
	input wire logic cap_client,
	input wire logic [DATA_W-1:0] cap_data,
	input wire logic cap_last,
	input wire logic [4:0] cap_last_bytes,
	output logic cap_ready,
	// memory write command
	output logic mem_cmd_valid,
	output logic [ADDR_W-1:0] mem_cmd_addr,
	output logic [LEN_W-1:0] mem_cmd_bytes,
	input wire logic mem_cmd_ready,
	// memory write data
	output logic mem_wr_valid,
	output logic [DATA_W-1:0] mem_wr_data,
	input wire logic mem_wr_ready,
	// status
	output logic [LEN_W-1:0] last_remainder,
	output logic busy
);
	localparam logic [LEN_W-1:0] BURST_LEN = LEN_W'(BURST_BYTES);
	localparam logic [LEN_W-1:0] BEAT_LEN = LEN_W'(BEAT_BYTES);

	vlbw_state_t state_r, state_nxt;
	logic client_r, client_nxt;
	logic [LEN_W-1:0] acc_r, acc_nxt;
	logic [ADDR_W-1:0] line_addr_r [NUM_CLIENTS];
	logic [ADDR_W-1:0] line_addr_nxt [NUM_CLIENTS];
	logic [ADDR_W-1:0] burst_off_r, burst_off_nxt;
	logic [LEN_W-1:0] rem_r [NUM_CLIENTS][2];
	logic [LEN_W-1:0] rem_nxt [NUM_CLIENTS][2];
	logic sel_r [NUM_CLIENTS];
	logic sel_nxt [NUM_CLIENTS];
	logic chroma_skip_r, chroma_skip_nxt;
	logic [LEN_W-1:0] cmd_len_r, cmd_len_nxt;
	logic [ADDR_W-1:0] cmd_addr_r, cmd_addr_nxt;
	logic [LEN_W-1:0] last_rem_r, last_rem_nxt;
	logic is_final_r, is_final_nxt;
	logic buf_in_valid, buf_in_ready;
	logic [DATA_W-1:0] buf_in_data;
	logic beat_take, beat_drop;
	logic [LEN_W-1:0] beat_bytes;

	// a beat carries full 16 bytes unless it ends the line
	function automatic logic [LEN_W-1:0] beat_size(input logic last, input logic [4:0] nbytes);
		if (last && nbytes != 5'h00 && nbytes < 5'h10) begin
			return LEN_W'(nbytes);
		end
		return BEAT_LEN;
	endfunction : beat_size

	assign beat_bytes = beat_size(cap_last, cap_last_bytes);
	// 420 chroma: only every other line reaches memory, the downsampler
	// having merged pairs; dropped lines still drain the parser
	assign beat_drop = chroma_420 && cap_client == CLIENT_CHROMA && chroma_skip_r;
	assign beat_take = cap_valid && cap_ready && !beat_drop;
	assign cap_ready = (state_r == VLBW_IDLE || state_r == VLBW_DATA) && (beat_drop || buf_in_ready);
	assign buf_in_valid = cap_valid && !beat_drop && (state_r == VLBW_IDLE || state_r == VLBW_DATA);
	assign buf_in_data = cap_data;
	assign mem_cmd_valid = (state_r == VLBW_CMD);
	assign mem_cmd_addr = cmd_addr_r;
	assign mem_cmd_bytes = cmd_len_r;
	assign last_remainder = last_rem_r;
	assign busy = (state_r != VLBW_IDLE);

	// buffered data is offered to memory at once, without waiting for its command; a stalled
	// memory side fills the buffer and back-pressures the parser instead of losing a beat
	vlbw_skid #(
		.WIDTH(DATA_W)
	) u_buf (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(buf_in_valid),
		.in_data(buf_in_data),
		.in_ready(buf_in_ready),
		.out_valid(mem_wr_valid),
		.out_data(mem_wr_data),
		.out_ready(mem_wr_ready)
	);

	always_comb begin
		state_nxt = state_r;
		client_nxt = client_r;
		acc_nxt = acc_r;
		line_addr_nxt = line_addr_r;
		burst_off_nxt = burst_off_r;
		rem_nxt = rem_r;
		sel_nxt = sel_r;
		chroma_skip_nxt = chroma_skip_r;
		cmd_len_nxt = cmd_len_r;
		cmd_addr_nxt = cmd_addr_r;
		last_rem_nxt = last_rem_r;
		is_final_nxt = is_final_r;
		// frame size is whatever the upstream scaler emits; only frame_start delimits it
		if (frame_start) begin
			line_addr_nxt[CLIENT_LUMA] = luma_base;
			line_addr_nxt[CLIENT_CHROMA] = chroma_base;
			chroma_skip_nxt = 1'b0;
		end
		if (cap_valid && cap_ready && beat_drop && cap_last) begin
			chroma_skip_nxt = 1'b0;
		end
		case (state_r)
			VLBW_IDLE, VLBW_DATA: begin
				if (beat_take) begin
					client_nxt = cap_client;
					acc_nxt = acc_r + beat_bytes;
					state_nxt = VLBW_DATA;
					if (cap_last) begin
						// remainder of this very line, stored in this client's
						// ping-pong slot and used directly for the command
						rem_nxt[cap_client][sel_r[cap_client]] = acc_r + beat_bytes;
						sel_nxt[cap_client] = ~sel_r[cap_client];
						cmd_len_nxt = acc_r + beat_bytes;
						last_rem_nxt = acc_r + beat_bytes;
						cmd_addr_nxt = line_addr_r[cap_client] + burst_off_r;
						is_final_nxt = 1'b1;
						state_nxt = VLBW_CMD;
						if (cap_client == CLIENT_CHROMA && chroma_420) begin
							chroma_skip_nxt = 1'b1;
						end
					end else if (acc_r + beat_bytes == BURST_LEN) begin
						cmd_len_nxt = BURST_LEN;
						cmd_addr_nxt = line_addr_r[cap_client] + burst_off_r;
						is_final_nxt = 1'b0;
						state_nxt = VLBW_CMD;
					end
				end
			end
			VLBW_CMD: begin
				if (mem_cmd_ready) begin
					acc_nxt = '0;
					if (is_final_r) begin
						state_nxt = VLBW_ADV;
					end else begin
						burst_off_nxt = burst_off_r + ADDR_W'(BURST_BYTES);
						state_nxt = VLBW_DATA;
					end
				end
			end
			VLBW_ADV: begin
				line_addr_nxt[client_r] = line_addr_r[client_r] + line_stride;
				burst_off_nxt = '0;
				state_nxt = VLBW_IDLE;
			end
			default: state_nxt = VLBW_IDLE;
		endcase
		if (client_abort) begin
			// abort drops the line in flight and zeroes the remainders
			for (int c = 0; c < NUM_CLIENTS; c++) begin
				rem_nxt[c][0] = REM_RESET;
				rem_nxt[c][1] = REM_RESET;
				sel_nxt[c] = 1'b0;
			end
			acc_nxt = '0;
			burst_off_nxt = '0;
			last_rem_nxt = REM_RESET;
			chroma_skip_nxt = 1'b0;
			state_nxt = VLBW_IDLE;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= VLBW_IDLE;
			client_r <= CLIENT_LUMA;
			acc_r <= '0;
			burst_off_r <= '0;
			chroma_skip_r <= 1'b0;
			cmd_len_r <= '0;
			cmd_addr_r <= '0;
			last_rem_r <= REM_RESET;
			is_final_r <= 1'b0;
			for (int c = 0; c < NUM_CLIENTS; c++) begin
				line_addr_r[c] <= ADDR_RESET;
				rem_r[c][0] <= REM_RESET;
				rem_r[c][1] <= REM_RESET;
				sel_r[c] <= 1'b0;
			end
		end else begin
			state_r <= state_nxt;
			client_r <= client_nxt;
			acc_r <= acc_nxt;
			burst_off_r <= burst_off_nxt;
			chroma_skip_r <= chroma_skip_nxt;
			cmd_len_r <= cmd_len_nxt;
			cmd_addr_r <= cmd_addr_nxt;
			last_rem_r <= last_rem_nxt;
			is_final_r <= is_final_nxt;
			line_addr_r <= line_addr_nxt;
			rem_r <= rem_nxt;
			sel_r <= sel_nxt;
		end
	end
endmodule : vlbw_writer

// ===== sim/vlbw_writer_properties.sv
/* port checker for vlbw_writer; assumes it is bound onto that module and sees only its ports. */
module vlbw_chk import vlbw_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// capture side
	input wire logic chroma_420,
	input wire logic client_abort,
	input wire logic cap_valid,
	input wire logic cap_client,
	input wire logic cap_last,
	input wire logic cap_ready,
	// memory side and status
	input wire logic mem_cmd_valid,
	input wire logic [31:0] mem_cmd_addr,
	input wire logic [7:0] mem_cmd_bytes,
	input wire logic mem_cmd_ready,
	input wire logic mem_wr_valid,
	input wire logic [127:0] mem_wr_data,
	input wire logic mem_wr_ready,
	input wire logic [7:0] last_remainder
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_burst_max: assert property (mem_cmd_valid |-> mem_cmd_bytes <= 8'h80)
		else $error("transfer too long");
	a_no_zero_size: assert property (mem_cmd_valid |-> mem_cmd_bytes != 8'h00)
		else $error("zero size transfer");
	a_cmd_hold: assert property (mem_cmd_valid && !mem_cmd_ready && !client_abort
		|=> client_abort || mem_cmd_valid && $stable(mem_cmd_addr) && $stable(mem_cmd_bytes))
		else $error("command dropped");
	a_wr_hold: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_data))
		else $error("write beat dropped");
	a_cmd_blocks: assert property (mem_cmd_valid |-> !cap_ready)
		else $error("beat taken while command waits");
	a_line_cmd: assert property (cap_valid && cap_ready && cap_last && !client_abort
		&& !(cap_client && chroma_420) |=> client_abort || mem_cmd_valid)
		else $error("no command at line end");
	a_rem_clear: assert property (client_abort |=> last_remainder == 8'h00)
		else $error("remainder kept over abort");
	a_rem_source: assert property ($changed(last_remainder) && !$past(client_abort)
		|-> mem_cmd_valid && last_remainder == mem_cmd_bytes)
		else $error("remainder not from final transfer");
endmodule : vlbw_chk

bind vlbw_writer vlbw_chk chk (.core_clk, .reset, .chroma_420, .client_abort, .cap_valid, .cap_client, .cap_last,
	.cap_ready, .mem_cmd_valid, .mem_cmd_addr, .mem_cmd_bytes, .mem_cmd_ready, .mem_wr_valid, .mem_wr_data,
	.mem_wr_ready, .last_remainder);

// ===== sim/vlbw_mem_model.sv
/* memory controller stand-in; assumes one writer and logs taken commands for the bench. */
module vlbw_mem_model (
	// clock, reset and stall mode
	input wire logic core_clk,
	input wire logic reset,
	input wire logic slow,
	// command and data channels
	input wire logic mem_cmd_valid,
	input wire logic [31:0] mem_cmd_addr,
	input wire logic [7:0] mem_cmd_bytes,
	output logic mem_cmd_ready,
	input wire logic mem_wr_valid,
	input wire logic [127:0] mem_wr_data,
	output logic mem_wr_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] tick_r;
	logic [39:0] cmd_q[$];
	int beats;
	logic [127:0] last_wr;
	// slow mode stalls both channels so the writer's buffer fills and refuses
	assign mem_cmd_ready = !slow || tick_r == 3'h5;
	assign mem_wr_ready = !slow || tick_r[0];
	always @(posedge core_clk) begin
		tick_r <= reset ? 3'h0 : tick_r + 3'h1;
		if (mem_cmd_valid && mem_cmd_ready)
			cmd_q.push_back({mem_cmd_addr, mem_cmd_bytes});
		if (mem_wr_valid && mem_wr_ready) begin
			beats++;
			last_wr = mem_wr_data;
		end
	end
endmodule : vlbw_mem_model

// ===== sim/test_video_capture_line_burst_writer.sv
/* bench for vlbw_writer with the memory stand-in; assumes the bound port checker. */
module test_video_capture_line_burst_writer;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, reset, chroma_420, frame_start, client_abort, cap_valid, cap_client, cap_last, slow;
	logic [31:0] luma_base = 32'h10000000, chroma_base = 32'h20000000, line_stride = 32'h00000400;
	logic [127:0] cap_data = 128'h0;
	logic [4:0] cap_last_bytes = 5'h00;
	logic cap_ready, mem_cmd_valid, mem_cmd_ready, mem_wr_valid, mem_wr_ready, busy;
	logic [31:0] mem_cmd_addr;
	logic [127:0] mem_wr_data;
	logic [7:0] mem_cmd_bytes, last_remainder;
	int errors, samples_checked, line_no[2];
	// six lines of mixed length in one frame on purpose: the writer must not rely on the scaler or source guards
	// client, slow drain, line bytes, expected final size
	int rows[6][4] = '{'{0, 0, 10, 10}, '{1, 0, 33, 33}, '{0, 0, 128, 128}, '{0, 1, 300, 44}, '{1, 1, 144, 16},
		'{0, 1, 256, 128}};
	vlbw_writer uut (.core_clk, .reset, .luma_base, .chroma_base, .line_stride, .chroma_420, .frame_start,
		.client_abort, .cap_valid, .cap_client, .cap_data, .cap_last, .cap_last_bytes, .cap_ready, .mem_cmd_valid,
		.mem_cmd_addr, .mem_cmd_bytes, .mem_cmd_ready, .mem_wr_valid, .mem_wr_data, .mem_wr_ready,
		.last_remainder, .busy);
	vlbw_mem_model mem (.core_clk, .reset, .slow, .mem_cmd_valid, .mem_cmd_addr, .mem_cmd_bytes, .mem_cmd_ready,
		.mem_wr_valid, .mem_wr_data, .mem_wr_ready);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask : pulse
	// cap_ready is read just before the rising edge, where it has settled
	task automatic send(input logic cl, input int len);
		bit ok;
		int t;
		for (int b = 0; b < (len + 15) / 16; b++) begin
			{cap_valid, cap_client, cap_last} = {1'b1, cl, b == (len - 1) / 16};
			cap_data = 128'(b + 1);
			cap_last_bytes = 5'(len - 16 * b);
			t = 0;
			do begin
				#2 ok = cap_ready;
				@(negedge core_clk);
				t++;
			end while (!ok && t < 200);
		end
		cap_valid = 1'b0;
	endtask : send
	task automatic line(input logic cl, input int len, input int rem);
		int n;
		logic [31:0] a;
		n = (len + 127) / 128;
		a = (cl ? chroma_base : luma_base) + line_stride * line_no[cl];
		mem.cmd_q.delete();
		mem.beats = 0;
		send(cl, len);
		for (int i = 0; i < 300 && (busy !== 1'b0 || mem.beats < (len + 15) / 16); i++)
			@(negedge core_clk);
		chk(40'(mem.cmd_q.size()), 40'(n));
		foreach (mem.cmd_q[k])
			chk(mem.cmd_q[k], {a + 32'(128 * k), 8'(k < n - 1 ? 128 : rem)});
		chk(40'(last_remainder), 40'(rem));
		chk(40'(mem.beats), 40'((len + 15) / 16));
		chk(mem.last_wr[39:0], 40'((len + 15) / 16));
		line_no[cl]++;
	endtask : line
	// the whole run needs a few hundred cycles; forty thousand means a hang
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end
	initial begin
		{reset, chroma_420, frame_start, client_abort, cap_valid, cap_client, cap_last, slow} = 8'h80;
		repeat (8) @(negedge core_clk);
		chk({busy, mem_cmd_valid, mem_wr_valid, cap_ready, last_remainder}, 40'h100);
		reset = 1'b0;
		pulse(frame_start);
		foreach (rows[r]) begin
			slow = rows[r][1][0];
			line(rows[r][0][0], rows[r][2], rows[r][3]);
		end
		{slow, chroma_420} = 2'h1;
		line_no = '{0, 0};
		pulse(frame_start);
		line(1'b1, 40, 40);
		send(1'b1, 40);
		repeat (20) @(negedge core_clk);
		chk(40'(mem.cmd_q.size()), 40'h1);
		chroma_420 = 1'b0;
		send(1'b0, 200);
		pulse(client_abort);
		chk(40'(last_remainder), 40'h0);
		repeat (10) @(negedge core_clk);
		for (int f = 0; f < 2; f++) begin
			line_no = '{0, 0};
			pulse(frame_start);
			line(1'b0, 10 + f, 10 + f);
		end
		pulse(reset);
		line_no = '{0, 0};
		pulse(frame_start);
		line(1'b1, 7, 7);
		report_and_stop();
	end
endmodule : test_video_capture_line_burst_writer
